/* tps_cfg.svh */
// Register offsets, field positions, reset values and timing counts for the timer
`ifndef TPS_CFG_SVH
`define TPS_CFG_SVH
`define TPS_IDX_COUNT      8'h01
`define TPS_IDX_CONFIG     8'h81
`define TPS_IDX_IRQCTL     8'h0b
`define TPS_IDX_CONTROL    8'h0c
`define TPS_IDX_WDT        8'h0d
`define TPS_CFG_RESET      8'h7b
`define TPS_IRQ_RESET      8'h00
`define TPS_BIT_EXT_EDGE   6
`define TPS_BIT_SRC        5
`define TPS_BIT_EDGE       4
`define TPS_BIT_ASSIGN     3
`define TPS_BIT_GIE        7
`define TPS_BIT_OVIE       5
`define TPS_BIT_OVF        2
`define TPS_BIT_INTF       1
`define TPS_BIT_WATCHDOG_CLEAR_OP     0
`define TPS_BIT_SLEEP      1
`define TPS_INSTR_DIV      2'h3
`define TPS_WRITE_HOLD     2'h2
`endif

/* tps_pkg.sv */
// Types shared by the timer block
package tps_pkg;
   typedef struct packed {
      logic       ext_interrupt_edge;
      logic       clock_source_select;
      logic       count_edge_select;
      logic       prescaler_assign;
      logic [2:0] ratio_select;
   } tps_config_s;
   typedef enum logic [2:0] {
      TPS_IDLE = 3'h1,
      TPS_ACK  = 3'h2,
      TPS_GAP  = 3'h4
   } tps_bus_e;
endpackage : tps_pkg

/* tps_edge_detect.sv */
// Synchroniser with selectable-edge pulse detector
`timescale 1ns/1ns
module tps_edge_detect (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic pin,
   input  wire logic falling,
   output logic      pulse
);
   logic s1_reg, s2_reg, s3_reg;
   logic s1_next, s2_next, s3_next;
   always_comb begin
      s1_next = pin;
      s2_next = s1_reg;
      s3_next = s2_reg;
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
      end
   end
   // Only the second and third stages feed the edge test
   assign pulse = falling ? (s3_reg & ~s2_reg) : (~s3_reg & s2_reg);
endmodule : tps_edge_detect

/* tps_timer.sv */
// Eight-bit timer/counter with a prescaler shared with the watchdog
`timescale 1ns/1ns
`include "tps_cfg.svh"
module tps_timer
   import tps_pkg::*;
#(
   parameter int WDT_WIDTH = 16
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        ext_count_pin,
   input  wire logic        ext_int_pin,
   output logic             irq_o,
   output logic             wdt_tick_o,
   output logic             ext_int_event_o
);
   tps_bus_e              bus_reg, bus_next;
   logic [31:0]           dat_reg, dat_next;
   logic [7:0]            count_reg, count_next;
   tps_config_s           cfg_reg, cfg_next;
   logic [7:0]            irqctl_reg, irqctl_next;
   logic                  sleep_reg, sleep_next;
   logic [7:0]            pre_reg, pre_next;
   logic [1:0]            phase_reg, phase_next;
   logic [1:0]            hold_reg, hold_next;
   logic [WDT_WIDTH-1:0]  wdt_reg, wdt_next;
   logic                  irq_reg, irq_next;
   logic                  tick_reg, tick_next;
   logic                  eint_reg, eint_next;
   logic                  count_pulse, eint_pulse;
   logic                  wr, rd_go;
   logic [7:0]            idx, wbyte;

   // Byte address is four times the register index
   function automatic logic hit(input logic [7:0] want);
      hit = (idx == want);
   endfunction : hit

   // Prescaler output bit for a given ratio; n selects bit n of the divider
   function automatic logic pre_edge(input logic [7:0] oldv, input logic [7:0] newv,
                                     input logic [2:0] n);
      pre_edge = oldv[n] & ~newv[n];
   endfunction : pre_edge

   assign idx   = wb_adr_i[9:2];
   assign wbyte = wb_dat_i[7:0];
   assign wr    = (bus_reg == TPS_IDLE) && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
   assign rd_go = (bus_reg == TPS_IDLE) && wb_cyc_i && wb_stb_i;

   tps_edge_detect u_tcki (
      .clock   (clock),
      .rst     (rst),
      .pin     (ext_count_pin),
      .falling (cfg_reg.count_edge_select),
      .pulse   (count_pulse)
   );
   tps_edge_detect u_int (
      .clock   (clock),
      .rst     (rst),
      .pin     (ext_int_pin),
      .falling (~cfg_reg.ext_interrupt_edge),
      .pulse   (eint_pulse)
   );

   // Bus slave: ack one cycle after request, then one idle cycle
   always_comb begin
      bus_next = bus_reg;
      dat_next = dat_reg;
      case (bus_reg)
         TPS_IDLE: begin
            if (rd_go) begin
               bus_next = TPS_ACK;
               dat_next = 32'h0;
               if (hit(`TPS_IDX_COUNT))
                  dat_next = {24'h0, count_reg};
               else if (hit(`TPS_IDX_CONFIG))
                  dat_next = {25'h0, cfg_reg};
               else if (hit(`TPS_IDX_IRQCTL))
                  dat_next = {24'h0, irqctl_reg};
               else if (hit(`TPS_IDX_CONTROL))
                  dat_next = {30'h0, sleep_reg, 1'b0};
               else if (hit(`TPS_IDX_WDT))
                  dat_next = 32'(wdt_reg);
            end
         end
         TPS_ACK:  bus_next = TPS_GAP;
         TPS_GAP:  bus_next = TPS_IDLE;
         default:  bus_next = TPS_IDLE;
      endcase
   end

   // Counting datapath
   always_comb begin
      logic inc_src, inc, wdt_src, clr_pre, wd_own, watchdog_clear_op;
      inc_src     = 1'b0;
      inc         = 1'b0;
      wdt_src     = 1'b0;
      clr_pre     = 1'b0;
      watchdog_clear_op      = wr && hit(`TPS_IDX_CONTROL) && wbyte[`TPS_BIT_WATCHDOG_CLEAR_OP];
      wd_own      = cfg_reg.prescaler_assign;
      count_next  = count_reg;
      cfg_next    = cfg_reg;
      irqctl_next = irqctl_reg;
      sleep_next  = sleep_reg;
      pre_next    = pre_reg;
      hold_next   = hold_reg;
      wdt_next    = wdt_reg;
      tick_next   = 1'b0;
      eint_next   = eint_pulse;
      phase_next  = sleep_reg ? phase_reg : phase_reg + 2'h1;
      // Source event: instruction period or pin edge, frozen in sleep
      if (!sleep_reg) begin
         if (cfg_reg.clock_source_select)
            inc_src = count_pulse;
         else
            inc_src = (phase_reg == `TPS_INSTR_DIV);
      end
      wdt_src = !sleep_reg && (phase_reg == `TPS_INSTR_DIV);
      if (wd_own) begin
         inc = inc_src;
         pre_next = wdt_src ? pre_reg + 8'h1 : pre_reg;
         wdt_src  = (cfg_reg.ratio_select == 3'h0) ? wdt_src
                  : (wdt_src && pre_edge(pre_reg, pre_next, cfg_reg.ratio_select - 3'h1));
      end else begin
         pre_next = inc_src ? pre_reg + 8'h1 : pre_reg;
         inc = inc_src && pre_edge(pre_reg, pre_next, cfg_reg.ratio_select);
      end
      // Write-hold window counts down in instruction periods
      if (hold_reg != 2'h0) begin
         if (phase_reg == `TPS_INSTR_DIV)
            hold_next = hold_reg - 2'h1;
         inc = 1'b0;
      end
      if (inc) begin
         count_next = count_reg + 8'h1;
         if (count_reg == 8'hff)
            irqctl_next[`TPS_BIT_OVF] = 1'b1;
      end
      if (wdt_src) begin
         wdt_next = wdt_reg + 1'b1;
         if (&wdt_reg)
            tick_next = 1'b1;
      end
      if (eint_pulse)
         irqctl_next[`TPS_BIT_INTF] = 1'b1;
      if (wr && hit(`TPS_IDX_COUNT)) begin
         count_next = wbyte;
         hold_next  = `TPS_WRITE_HOLD;
         if (!wd_own)
            clr_pre = 1'b1;
      end
      if (wr && hit(`TPS_IDX_CONFIG))
         cfg_next = wbyte[6:0];
      if (wr && hit(`TPS_IDX_IRQCTL)) begin
         // Hardware set wins over a same-cycle software clear
         irqctl_next = wbyte | (irqctl_reg & 8'h0 );
         if (inc && count_reg == 8'hff)
            irqctl_next[`TPS_BIT_OVF] = 1'b1;
         if (eint_pulse)
            irqctl_next[`TPS_BIT_INTF] = 1'b1;
      end
      if (wr && hit(`TPS_IDX_CONTROL))
         sleep_next = wbyte[`TPS_BIT_SLEEP];
      if (watchdog_clear_op) begin
         wdt_next = '0;
         if (wd_own)
            clr_pre = 1'b1;
      end
      if (clr_pre)
         pre_next = 8'h0;
      irq_next = irqctl_next[`TPS_BIT_GIE] && irqctl_next[`TPS_BIT_OVIE]
               && irqctl_next[`TPS_BIT_OVF];
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         bus_reg    <= TPS_IDLE;
         dat_reg    <= 32'h0;
         count_reg  <= 8'h0;
         cfg_reg    <= tps_config_s'(7'(`TPS_CFG_RESET));
         irqctl_reg <= `TPS_IRQ_RESET;
         sleep_reg  <= 1'b0;
         pre_reg    <= 8'h0;
         phase_reg  <= 2'h0;
         hold_reg   <= 2'h0;
         wdt_reg    <= '0;
         irq_reg    <= 1'b0;
         tick_reg   <= 1'b0;
         eint_reg   <= 1'b0;
      end else begin
         bus_reg    <= bus_next;
         dat_reg    <= dat_next;
         count_reg  <= count_next;
         cfg_reg    <= cfg_next;
         irqctl_reg <= irqctl_next;
         sleep_reg  <= sleep_next;
         pre_reg    <= pre_next;
         phase_reg  <= phase_next;
         hold_reg   <= hold_next;
         wdt_reg    <= wdt_next;
         irq_reg    <= irq_next;
         tick_reg   <= tick_next;
         eint_reg   <= eint_next;
      end
   end

   assign wb_dat_o        = dat_reg;
   assign wb_ack_o        = (bus_reg == TPS_ACK);
   assign irq_o           = irq_reg;
   assign wdt_tick_o      = tick_reg;
   assign ext_int_event_o = eint_reg;
endmodule : tps_timer

/* tps_timer_properties.sv */
// Concurrent checks on the timer's bus and event outputs
`timescale 1ns/1ns
`include "tps_cfg.svh"
module tps_timer_properties
   import tps_pkg::*;
#(
   parameter int WDT_WIDTH = 16
) (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        ext_count_pin,
   input wire logic        ext_int_pin,
   input wire logic        irq_o,
   input wire logic        wdt_tick_o,
   input wire logic        ext_int_event_o
);
   logic [7:0] idx;
   assign idx = wb_adr_i[9:2];
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_take;
      $rose(wb_cyc_i && wb_stb_i);
   endsequence
   sequence s_irq_off;
      wb_ack_o && wb_we_i && wb_sel_i[0] && idx == `TPS_IDX_IRQCTL && !wb_dat_i[`TPS_BIT_OVIE];
   endsequence
   a_ack_one_shot: assert property (s_take |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single pulse after request");
   a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_read_high_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && !(idx inside {`TPS_IDX_COUNT,
      `TPS_IDX_CONFIG, `TPS_IDX_IRQCTL, `TPS_IDX_CONTROL, `TPS_IDX_WDT}) |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_cfg_top_zero: assert property (wb_ack_o && !wb_we_i && idx == `TPS_IDX_CONFIG
      |-> !wb_dat_o[7])
      else $error("unused config bit read as one");
   a_irq_drop: assert property (s_irq_off |-> ##[1:2] !irq_o)
      else $error("irq stayed up after enable cleared");
   a_wdt_tick_pulse: assert property (wdt_tick_o |=> !wdt_tick_o)
      else $error("watchdog tick longer than one cycle");
   a_ext_ev_pulse: assert property (ext_int_event_o |=> !ext_int_event_o)
      else $error("external event longer than one cycle");
   a_ext_ev_cause: assert property ($stable(ext_int_pin) [*6] |=> !ext_int_event_o)
      else $error("external event without pin edge");
endmodule : tps_timer_properties
bind tps_timer tps_timer_properties #(.WDT_WIDTH(WDT_WIDTH)) u_props (
   .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .ext_count_pin(ext_count_pin), .ext_int_pin(ext_int_pin),
   .irq_o(irq_o), .wdt_tick_o(wdt_tick_o), .ext_int_event_o(ext_int_event_o)
);

/* tps_timer_test.sv */
// Self-checking bench for the timer block
`timescale 1ns/1ns
`include "tps_cfg.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tps_timer_test
   import tps_pkg::*;
;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, cpin = 1'b0, ipin = 1'b0;
   logic [31:0] adr = 32'h0, wdat = 32'h0, dat_o;
   logic [3:0]  sel = 4'hf;
   logic        ack, irq, tick, iev;
   logic [7:0]  rd, a;
   logic [7:0]  tbl [4] = '{8'h48, 8'h40, 8'h41, 8'h47};
   int          err_count = 0, tests_run = 0, i, p, t0, cycn = 0, evn = 0, tlast = 0, tprev = 0;
   tps_timer #(.WDT_WIDTH(4)) uut (
      .clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .ext_count_pin(cpin), .ext_int_pin(ipin), .irq_o(irq), .wdt_tick_o(tick),
      .ext_int_event_o(iev)
   );
   initial begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycn <= cycn + 1;
      if (iev === 1'b1) evn <= evn + 1;
      if (tick === 1'b1) begin
         tprev <= tlast;
         tlast <= cycn;
      end
   end
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   // Holds the request until ack, then leaves two idle cycles before the next
   task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clock);
      {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, 22'h0, ix, 2'h0, 24'h0, d};
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 20);
      // A missing answer is a mismatch, not a silent pass
      if (ack !== 1'b1) err_count++;
      rd = dat_o[7:0];
      {cyc, stb, we} <= 3'h0;
      @(posedge clock);
   endtask : bus
   initial begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      bus(0, `TPS_IDX_CONFIG, 8'h0);
      `CHK(rd, `TPS_CFG_RESET)
      bus(1, 8'h20, 8'hff);
      bus(0, 8'h20, 8'h0);
      `CHK(rd, 8'h00)
      // Window is a whole number of count periods, so phase does not matter
      for (i = 0; i < 4; i++) begin
         p = tbl[i][3] ? 4 : 4 << (tbl[i][2:0] + 1);
         bus(1, `TPS_IDX_CONTROL, 8'h01);
         bus(1, `TPS_IDX_CONFIG, tbl[i]);
         bus(1, `TPS_IDX_CONTROL, 8'h01);
         bus(0, `TPS_IDX_COUNT, 8'h0);
         a = rd;
         repeat (3 * p - 4) @(posedge clock);
         bus(0, `TPS_IDX_COUNT, 8'h0);
         `CHK(rd, a + 8'h3)
      end
      bus(1, `TPS_IDX_CONFIG, 8'h48);
      bus(1, `TPS_IDX_COUNT, 8'h10);
      bus(0, `TPS_IDX_COUNT, 8'h0);
      `CHK(rd, 8'h10)
      bus(1, `TPS_IDX_COUNT, 8'h00);
      bus(1, `TPS_IDX_IRQCTL, 8'h20);
      bus(1, `TPS_IDX_COUNT, 8'hfe);
      repeat (30) @(posedge clock);
      `CHK(irq, 1'b0)
      bus(0, `TPS_IDX_IRQCTL, 8'h0);
      `CHK(rd[2], 1'b1)
      bus(1, `TPS_IDX_IRQCTL, 8'ha4);
      @(posedge clock);
      `CHK(irq, 1'b1)
      bus(1, `TPS_IDX_IRQCTL, 8'h84);
      @(posedge clock);
      `CHK(irq, 1'b0)
      repeat (300) @(posedge clock);
      bus(0, `TPS_IDX_IRQCTL, 8'h0);
      `CHK(rd[2], 1'b1)
      bus(1, `TPS_IDX_CONTROL, 8'h02);
      bus(1, `TPS_IDX_IRQCTL, 8'h00);
      bus(0, `TPS_IDX_IRQCTL, 8'h0);
      `CHK(rd[2], 1'b0)
      bus(0, `TPS_IDX_COUNT, 8'h0);
      a = rd;
      repeat (100) @(posedge clock);
      bus(0, `TPS_IDX_COUNT, 8'h0);
      `CHK(rd, a)
      bus(1, `TPS_IDX_CONTROL, 8'h00);
      for (i = 0; i < 2; i++) begin
         bus(1, `TPS_IDX_CONFIG, i ? 8'h68 : 8'h78);
         bus(1, `TPS_IDX_COUNT, 8'h0);
         repeat (12) @(posedge clock);
         repeat (5) begin
            cpin <= ~cpin;
            repeat (8) @(posedge clock);
         end
         bus(0, `TPS_IDX_COUNT, 8'h0);
         `CHK(rd, i ? 8'h3 : 8'h2)
         cpin <= 1'b0;
      end
      for (i = 0; i < 2; i++) begin
         bus(1, `TPS_IDX_CONFIG, i ? 8'h48 : 8'h08);
         t0 = evn;
         ipin <= 1'b1;
         repeat (10) @(posedge clock);
         `CHK(evn - t0, i)
         ipin <= 1'b0;
         repeat (10) @(posedge clock);
         `CHK(evn - t0, 1)
      end
      for (i = 0; i < 2; i++) begin
         p = i ? 256 : 64;
         bus(1, `TPS_IDX_CONFIG, i ? 8'h4a : 8'h48);
         repeat (3 * p) @(posedge clock);
         `CHK(tlast - tprev, p)
      end
      bus(1, `TPS_IDX_CONTROL, 8'h01);
      t0 = cycn;
      repeat (p - 8) @(posedge clock);
      `CHK(tlast <= t0, 1'b1)
      repeat (16) @(posedge clock);
      `CHK(tlast > t0, 1'b1)
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      end_sim();
   end
endmodule : tps_timer_test
